/* rtl/expander_host.sv */
// host controller for a two-wire 16-port i/o expander, apb programmed
// assumes open-drain scl/sda with pull-ups and a single bus master
//
// Summary of operation
// - idle bus: both lines released high, nobody drives them.
// - master opens every transfer with sda falling while scl high.
// - master closes every transfer with sda rising while scl high.
// - one bit per scl pulse; sda changes only while scl low.
// - eighth bit after the address: low writes, high reads.
// - first byte after a write address is the command byte.
// - nine clocks per byte; a receiving device holds sda low on the ninth.
// - device acks bytes it receives; master leaves sda released on the ninth clock of bytes it reads.
// - write: address with write bit, command byte, data byte.
// - read: address, command, repeated start, address with read bit.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module expander_host
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // serial clock, open drain
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   // serial data, open drain
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // device side-band
   input  wire logic        change_alert_n,
   output logic             bus_abort_n,
   output logic [1:0]       addr_sel
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] pins_sync;
   logic       scl_s;
   logic       sda_s;
   logic       alert_n_s;

   pin_sync
   #(
      .WIDTH (3)
   )
   u_sync
   (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .pin_in       ({change_alert_n, sda_in, scl_in}),
      .pin_sync_out (pins_sync)
   );

   assign scl_s     = pins_sync[0];
   assign sda_s     = pins_sync[1];
   assign alert_n_s = pins_sync[2];

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic        wr_acc;
   logic        rd_setup;
   logic        hit_ctrl;
   logic        hit_xfer;
   logic        hit_stat;
   logic        mapped;

   logic        read_op_reg;
   logic        abort_reg;
   logic [1:0]  sel_reg;
   logic [7:0]  cmd_reg;
   logic [7:0]  wdata_reg;
   logic [7:0]  rdata_reg;
   logic        done_reg;
   logic        nack_reg;
   logic [31:0] prdata_reg;
   logic        go;
   logic        busy;
   logic        done_set;
   logic        nack_set;

   assign hit_ctrl = (paddr == expander_host_pkg::CTRL_OFS);
   assign hit_xfer = (paddr == expander_host_pkg::XFER_OFS);
   assign hit_stat = (paddr == expander_host_pkg::STATUS_OFS);
   assign mapped   = hit_ctrl | hit_xfer | hit_stat;
   assign wr_acc   = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped;
   assign prdata   = prdata_reg;

   // go is taken only when idle and not aborting
   assign go = wr_acc & hit_ctrl & pwdata[expander_host_pkg::CTRL_GO_BIT]
             & ~busy & ~pwdata[expander_host_pkg::CTRL_ABORT_BIT];

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         read_op_reg <= 1'b0;
         abort_reg   <= 1'b0;
         sel_reg     <= expander_host_pkg::SEL_RESET;
      end
      else if (wr_acc && hit_ctrl)
      begin
         abort_reg <= pwdata[expander_host_pkg::CTRL_ABORT_BIT];
         sel_reg   <= pwdata[expander_host_pkg::CTRL_SEL_LSB +: 2];
         if (go)
         begin
            read_op_reg <= pwdata[expander_host_pkg::CTRL_READ_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_reg   <= expander_host_pkg::BYTE_RESET;
         wdata_reg <= expander_host_pkg::BYTE_RESET;
      end
      else if (wr_acc && hit_xfer && !busy)
      begin
         cmd_reg   <= pwdata[expander_host_pkg::XFER_CMD_LSB +: 8];
         wdata_reg <= pwdata[expander_host_pkg::XFER_DATA_LSB +: 8];
      end
   end

   // sticky flags: a set in the clearing cycle wins
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_reg <= 1'b0;
         nack_reg <= 1'b0;
      end
      else
      begin
         if (done_set)
            done_reg <= 1'b1;
         else if (wr_acc && hit_stat && pwdata[expander_host_pkg::STAT_DONE_BIT])
            done_reg <= 1'b0;
         if (nack_set)
            nack_reg <= 1'b1;
         else if (wr_acc && hit_stat && pwdata[expander_host_pkg::STAT_NACK_BIT])
            nack_reg <= 1'b0;
      end
   end

   // read data is latched in the setup cycle, so no wait states
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_reg <= 32'h0000_0000;
      end
      else if (rd_setup)
      begin
         prdata_reg <= 32'h0000_0000;
         if (hit_ctrl)
         begin
            prdata_reg[expander_host_pkg::CTRL_READ_BIT]  <= read_op_reg;
            prdata_reg[expander_host_pkg::CTRL_ABORT_BIT] <= abort_reg;
            prdata_reg[expander_host_pkg::CTRL_SEL_LSB +: 2] <= sel_reg;
         end
         else if (hit_xfer)
         begin
            prdata_reg[expander_host_pkg::XFER_CMD_LSB +: 8]  <= cmd_reg;
            prdata_reg[expander_host_pkg::XFER_DATA_LSB +: 8] <= wdata_reg;
         end
         else if (hit_stat)
         begin
            prdata_reg[expander_host_pkg::STAT_BUSY_BIT]  <= busy;
            prdata_reg[expander_host_pkg::STAT_DONE_BIT]  <= done_reg;
            prdata_reg[expander_host_pkg::STAT_NACK_BIT]  <= nack_reg;
            prdata_reg[expander_host_pkg::STAT_ALERT_BIT] <= ~alert_n_s;
            prdata_reg[expander_host_pkg::STAT_RDATA_LSB +: 8] <= rdata_reg;
         end
      end
   end

   assign bus_abort_n = ~abort_reg;
   assign addr_sel    = sel_reg;

   // ----------------------------------------------------------------
   // quarter-bit timing
   // ----------------------------------------------------------------
   expander_host_pkg::host_state_e state_reg;
   logic [expander_host_pkg::QCNT_W-1:0] qcnt_reg;
   logic [1:0]  phase_reg;
   logic        stretch;
   logic        tick;

   // a slave holding scl low stalls the high phase
   assign stretch = (phase_reg == 2'h2) & ~scl_s;
   assign tick    = (qcnt_reg == expander_host_pkg::QCNT_LAST) & ~stretch;
   assign busy    = (state_reg != expander_host_pkg::ST_IDLE);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         qcnt_reg  <= '0;
         phase_reg <= 2'h0;
      end
      else if (!busy || abort_reg)
      begin
         qcnt_reg  <= '0;
         phase_reg <= 2'h0;
      end
      else if (tick)
      begin
         qcnt_reg  <= '0;
         phase_reg <= phase_reg + 2'h1;
      end
      else if (!stretch)
      begin
         qcnt_reg <= qcnt_reg + {{(expander_host_pkg::QCNT_W-1){1'b0}}, 1'b1};
      end
   end

   // ----------------------------------------------------------------
   // step sequencer
   // ----------------------------------------------------------------
   logic [2:0]  step_reg;
   logic [2:0]  step_next;
   logic [3:0]  bit_reg;
   logic [7:0]  shift_reg;
   logic        rx_byte;
   logic        last_step;
   logic        acked_nack_reg;
   expander_host_pkg::host_state_e kind_next;
   logic [7:0]  byte_next;

   assign rx_byte   = read_op_reg & (step_reg == expander_host_pkg::STEP_RX);
   assign last_step = read_op_reg ? (step_reg == expander_host_pkg::STEP_RD_STOP)
                                  : (step_reg == expander_host_pkg::STEP_WR_STOP);

   // what the following step is and which byte it sends
   always_comb
   begin
      kind_next = expander_host_pkg::ST_BYTE;
      byte_next = 8'hff;
      case (step_next)
         expander_host_pkg::STEP_ADDR_WR:
            byte_next = {expander_host_pkg::ADDR_UPPER, sel_reg, 1'b0};
         expander_host_pkg::STEP_CMD:
            byte_next = cmd_reg;
         3'h3:
         begin
            if (read_op_reg)
               kind_next = expander_host_pkg::ST_START;
            else
               byte_next = wdata_reg;
         end
         3'h4:
         begin
            if (read_op_reg)
               byte_next = {expander_host_pkg::ADDR_UPPER, sel_reg, 1'b1};
            else
               kind_next = expander_host_pkg::ST_STOP;
         end
         expander_host_pkg::STEP_RX:
            byte_next = 8'hff;
         expander_host_pkg::STEP_RD_STOP:
            kind_next = expander_host_pkg::ST_STOP;
         default:
            kind_next = expander_host_pkg::ST_STOP;
      endcase
   end

   logic end_of_step;
   logic nack_seen;
   assign nack_seen   = (state_reg == expander_host_pkg::ST_BYTE) & tick
                      & (phase_reg == 2'h2) & (bit_reg == expander_host_pkg::ACK_SLOT)
                      & ~rx_byte & sda_s;
   assign end_of_step = tick & (phase_reg == 2'h3)
                      & ((state_reg != expander_host_pkg::ST_BYTE)
                         | (bit_reg == expander_host_pkg::ACK_SLOT));
   // a refused byte jumps straight to the stop
   assign step_next   = acked_nack_reg
                      ? (read_op_reg ? expander_host_pkg::STEP_RD_STOP
                                     : expander_host_pkg::STEP_WR_STOP)
                      : step_reg + 3'h1;
   assign nack_set    = nack_seen;
   assign done_set    = end_of_step & last_step;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= expander_host_pkg::ST_IDLE;
         step_reg  <= expander_host_pkg::STEP_START;
         bit_reg   <= 4'h0;
         shift_reg <= 8'hff;
      end
      else if (abort_reg)
      begin
         state_reg <= expander_host_pkg::ST_IDLE;
         step_reg  <= expander_host_pkg::STEP_START;
         bit_reg   <= 4'h0;
      end
      else
      begin
         case (state_reg)
            expander_host_pkg::ST_IDLE:
            begin
               if (go)
               begin
                  state_reg <= expander_host_pkg::ST_START;
                  step_reg  <= expander_host_pkg::STEP_START;
               end
            end
            expander_host_pkg::ST_START,
            expander_host_pkg::ST_BYTE,
            expander_host_pkg::ST_STOP:
            begin
               if (state_reg == expander_host_pkg::ST_BYTE && tick)
               begin
                  if (phase_reg == 2'h2 && bit_reg != expander_host_pkg::ACK_SLOT)
                     shift_reg <= {shift_reg[6:0], sda_s};
                  if (phase_reg == 2'h3 && bit_reg != expander_host_pkg::ACK_SLOT)
                     bit_reg <= bit_reg + 4'h1;
               end
               if (end_of_step)
               begin
                  bit_reg <= 4'h0;
                  if (last_step)
                  begin
                     state_reg <= expander_host_pkg::ST_IDLE;
                  end
                  else
                  begin
                     step_reg  <= step_next;
                     state_reg <= kind_next;
                     shift_reg <= byte_next;
                  end
               end
            end
            default:
               state_reg <= expander_host_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         acked_nack_reg <= 1'b0;
      else if (!busy)
         acked_nack_reg <= 1'b0;
      else if (nack_seen)
         acked_nack_reg <= 1'b1;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_reg <= expander_host_pkg::BYTE_RESET;
      else if (rx_byte && end_of_step)
         rdata_reg <= shift_reg;
   end

   // ----------------------------------------------------------------
   // line drivers
   // ----------------------------------------------------------------
   logic scl_oe_reg;
   logic sda_oe_reg;

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = scl_oe_reg;
   assign sda_oe  = sda_oe_reg;

   // byte bits move sda only in phase 0, when scl is held low; start and stop move it in phase 2, with scl high
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end
      else if (abort_reg || !busy)
      begin
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end
      else if (tick)
      begin
         case (phase_reg)
            2'h0:
            begin
               if (state_reg == expander_host_pkg::ST_STOP)
                  sda_oe_reg <= 1'b1;
               else if (state_reg == expander_host_pkg::ST_BYTE
                        && bit_reg != expander_host_pkg::ACK_SLOT && !rx_byte)
                  sda_oe_reg <= ~shift_reg[7];
               else
                  sda_oe_reg <= 1'b0; // ack slot and read bits released
            end
            2'h1:
               scl_oe_reg <= 1'b0;
            2'h2:
            begin
               if (state_reg == expander_host_pkg::ST_START)
                  sda_oe_reg <= 1'b1;
               else if (state_reg == expander_host_pkg::ST_STOP)
                  sda_oe_reg <= 1'b0;
            end
            default:
               scl_oe_reg <= (state_reg != expander_host_pkg::ST_STOP);
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_idle_released: assert property (!busy |-> !scl_oe_reg && !sda_oe_reg)
      else $error("bus lines driven while idle");
   a_start_edge: assert property (state_reg == expander_host_pkg::ST_START && tick
      && phase_reg == 2'h2 |=> sda_oe_reg && !scl_oe_reg)
      else $error("start not sda falling with scl high");
   a_stop_edge: assert property (state_reg == expander_host_pkg::ST_STOP && tick
      && phase_reg == 2'h2 && !abort_reg |=> !sda_oe_reg && !scl_oe_reg)
      else $error("stop not sda rising with scl high");
   a_sda_stable: assert property (busy && state_reg == expander_host_pkg::ST_BYTE
      && phase_reg != 2'h0 && $past(phase_reg) != 2'h0 |-> $stable(sda_oe_reg))
      else $error("sda moved outside scl low phase");
   a_addr_byte: assert property ($changed(step_reg)
      && step_reg == expander_host_pkg::STEP_ADDR_WR
      |-> shift_reg == {expander_host_pkg::ADDR_UPPER, sel_reg, 1'b0})
      else $error("wrong slave address byte");
   a_read_dir: assert property ($changed(step_reg) && read_op_reg
      && step_reg == expander_host_pkg::STEP_ADDR_RD |-> shift_reg[0])
      else $error("read address lacks read bit");
   a_cmd_byte: assert property ($changed(step_reg)
      && step_reg == expander_host_pkg::STEP_CMD |-> shift_reg == cmd_reg)
      else $error("command byte not sent after address");
   a_ack_release: assert property (state_reg == expander_host_pkg::ST_BYTE
      && bit_reg == expander_host_pkg::ACK_SLOT && phase_reg != 2'h0
      |-> !sda_oe_reg)
      else $error("master drove sda in ack slot");
   a_restart: assert property ($changed(step_reg) && read_op_reg
      && step_reg == expander_host_pkg::STEP_RESTART
      |-> state_reg == expander_host_pkg::ST_START)
      else $error("read lacks repeated start");
   a_abort_idle: assert property (abort_reg |=> !busy ##1 !scl_oe_reg)
      else $error("abort did not return to idle");

   c_write_done: cover property (done_set && !read_op_reg);
   c_read_done: cover property (done_set && read_op_reg);
   c_nack: cover property (nack_set);
   c_stretch: cover property (busy && stretch [*2]);

endmodule
`default_nettype wire

/* rtl/expander_host_pkg.sv */
// constants shared by the port-expander host controller
// assumes a 100 MHz system clock and an APB master on the software side
package expander_host_pkg;

   // ----------------------------------------------------------------
   // apb register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] XFER_OFS   = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;

   // ctrl fields
   localparam int CTRL_GO_BIT    = 0;
   localparam int CTRL_READ_BIT  = 1;
   localparam int CTRL_ABORT_BIT = 2;
   localparam int CTRL_SEL_LSB   = 8;
   // xfer fields
   localparam int XFER_CMD_LSB   = 0;
   localparam int XFER_DATA_LSB  = 8;
   // status fields
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_DONE_BIT  = 1;
   localparam int STAT_NACK_BIT  = 2;
   localparam int STAT_ALERT_BIT = 3;
   localparam int STAT_RDATA_LSB = 8;

   // reset values
   localparam logic [1:0] SEL_RESET  = 2'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // ----------------------------------------------------------------
   // device addressing and commands
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_UPPER = 5'h16;
   localparam logic [7:0] CMD_IN_A   = 8'h00;
   localparam logic [7:0] CMD_IN_B   = 8'h01;
   localparam logic [7:0] CMD_OUT_A  = 8'h02;
   localparam logic [7:0] CMD_OUT_B  = 8'h03;
   localparam logic [7:0] CMD_DIR_A  = 8'h04;
   localparam logic [7:0] CMD_DIR_B  = 8'h05;
   localparam logic [7:0] CMD_MASK_A = 8'h06;
   localparam logic [7:0] CMD_MASK_B = 8'h07;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 100;
   localparam int QUARTER_NS  = 625;
   localparam int QUARTER_CYC = (QUARTER_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int QCNT_W      = 7;
   localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(QUARTER_CYC - 1);

   // ----------------------------------------------------------------
   // transaction steps
   // ----------------------------------------------------------------
   localparam logic [2:0] STEP_START    = 3'h0;
   localparam logic [2:0] STEP_ADDR_WR  = 3'h1;
   localparam logic [2:0] STEP_CMD      = 3'h2;
   localparam logic [2:0] STEP_WDATA    = 3'h3;
   localparam logic [2:0] STEP_RESTART  = 3'h3;
   localparam logic [2:0] STEP_WR_STOP  = 3'h4;
   localparam logic [2:0] STEP_ADDR_RD  = 3'h4;
   localparam logic [2:0] STEP_RX       = 3'h5;
   localparam logic [2:0] STEP_RD_STOP  = 3'h6;
   localparam logic [3:0] ACK_SLOT      = 4'h8;

   typedef enum logic [3:0]
   {
      ST_IDLE  = 4'b0001,
      ST_START = 4'b0010,
      ST_BYTE  = 4'b0100,
      ST_STOP  = 4'b1000
   } host_state_e;

endpackage

/* rtl/pin_sync.sv */
// two-flop synchroniser bank for the serial-bus and alert pins
// assumes asynchronous pins and a free-running sys_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
   parameter int WIDTH = 3
)
(
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // pins in, synchronised out
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync_out
);

   // ----------------------------------------------------------------
   // per-bit double flop
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         logic meta_reg;
         logic sync_reg;
         // idle high: released open-drain lines read as one
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_reg <= 1'b1;
               sync_reg <= 1'b1;
            end
            else
            begin
               meta_reg <= pin_in[i];
               sync_reg <= meta_reg;
            end
         end
         assign pin_sync_out[i] = sync_reg;
      end
   endgenerate

endmodule
`default_nettype wire

/* dv/expander_model.sv */
// behavioural two-wire port expander standing at the host's far end
// assumes the bench resolves the pulled-up scl and sda wires
`timescale 1ns/1ps
`default_nettype none
module expander_model
(
   // serial bus
   input  wire logic        scl,
   input  wire logic        sda,
   output logic             sda_pull,
   // side-band
   input  wire logic [1:0]  sel,
   input  wire logic        abort_n,
   input  wire logic [15:0] pin_in,
   output logic             alert_n
);
   logic [7:0] sh, cmd, tx, rg [8], rf [2];
   logic [1:0] fl = 2'h0;
   int         bc = 0, ph = 15;
   // outputs follow the output register
   wire  [15:0] lvl = ({rg[5], rg[4]} & pin_in)
                    | (~{rg[5], rg[4]} & {rg[3], rg[2]});
   initial
   begin
      sda_pull = 0;
      foreach (rg[i]) rg[i] = 8'h00;
      rf = '{8'h00, 8'h00};
   end
   assign alert_n = ~|fl;
   always @*
      for (int i = 0; i < 2; i++)
         if (|((lvl[8*i+:8] ^ rf[i]) & rg[4+i] & ~rg[6+i]))
            fl[i] = 1;
   always @(negedge sda)
      if (scl)
      begin
         bc = 0;
         ph = 0;
      end
   always @(posedge sda)
      if (scl)
         ph = 15;
   always @(negedge abort_n)
   begin
      ph = 15;
      sda_pull = 0;
   end
   always @(posedge scl)
      if (ph < 9)
      begin
         sh = {sh[6:0], sda};
         bc++;
      end
   always @(negedge scl)
      if (ph < 9)
      begin
         sda_pull = 0;
         if (bc == 9)
         begin
            bc = 0;
            ph++;
         end
         if (bc == 8 && ph == 0 && sh[7:1] !== {5'h16, sel})
            ph = 15;
         else if (bc == 8 && ph < 3)
         begin
            sda_pull = 1;
            if (ph == 1)
               cmd = sh;
            if (ph == 2)
               rg[cmd[2:0]] = sh;
            if (ph == 0 && sh[0])
            begin
               ph = 7;
               tx = cmd < 2 ? lvl[8*cmd[0]+:8] : rg[cmd[2:0]];
               if (cmd < 2)
               begin
                  rf[cmd[0]] = tx;
                  fl[cmd[0]] = 0;
               end
            end
         end
         else if (ph == 8 && bc < 8)
            sda_pull = ~tx[7-bc];
      end
endmodule
`default_nettype wire

/* dv/expander_host_tb.sv */
// self-checking bench: apb master, wired bus and expander model
// assumes 100 MHz sys_clk and pulled-up serial wires
`timescale 1ns/1ps
`default_nettype none
module expander_host_tb;
   logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic        se;
   logic [7:0]  paddr = 0, c, d, cm [3] = '{8'h02, 8'h03, 8'h07};
   logic [31:0] pwdata = 0, rv, st;
   logic [15:0] pin_in = 0;
   logic [1:0]  dev_sel = 2'h2;
   wire         pready, pslverr, scl_oe, sda_oe, sda_pull, alert_n, abort_n;
   wire         scl_o, sda_o;
   wire  [31:0] prdata;
   wire  [1:0]  sel;
   // pull-ups: a released wire reads high
   wire         scl = ~(scl_oe & ~scl_o);
   wire         sda = ~((sda_oe & ~sda_o) | sda_pull);
   int          error_cnt = 0, n_compared = 0;
   expander_host DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .scl_in(scl),
      .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o),
      .sda_oe(sda_oe),
      .change_alert_n(alert_n), .bus_abort_n(abort_n), .addr_sel(sel));
   expander_model far_end (.scl(scl), .sda(sda), .sda_pull(sda_pull),
      .sel(dev_sel), .abort_n(abort_n), .pin_in(pin_in), .alert_n(alert_n));
   initial
      forever #5 sys_clk = ~sys_clk;
   task automatic finish_test;
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         error_cnt++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // a device answers only the select levels on its own pins
   function automatic logic exp_nack(logic [1:0] s);
      return s != dev_sel;
   endfunction
   task automatic apb(logic w, logic [7:0] a, logic [31:0] v);
      @(posedge sys_clk);
      psel    <= 1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= v;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rv = prdata;
      se = pslverr;
      psel    <= 0;
      penable <= 0;
   endtask
   // one serial transaction, status kept in st, sticky flags cleared
   task automatic xfer(logic r, logic [1:0] s, logic [7:0] k, logic [7:0] v);
      apb(1, expander_host_pkg::XFER_OFS, {16'h0, v, k});
      apb(1, expander_host_pkg::CTRL_OFS, {22'h0, s, 6'h0, r, 1'b1});
      do apb(0, expander_host_pkg::STATUS_OFS, 0); while (rv[1] !== 1'b1);
      st = rv;
      apb(1, expander_host_pkg::STATUS_OFS, 32'h6);
   endtask
   initial
   begin
      #1000000;
      error_cnt++;
      finish_test;
   end
   initial
   begin
      void'($urandom(32'hc4317288));
      repeat (4) @(posedge sys_clk);
      rst_n <= 1;
      apb(0, expander_host_pkg::STATUS_OFS, 0);
      chk(rv, 0);
      apb(0, 8'h0c, 0);
      chk(se, 1);
      chk(rv, 0);
      apb(1, expander_host_pkg::CTRL_OFS, 32'h4);
      @(negedge sys_clk);
      chk(abort_n, 0);
      apb(1, expander_host_pkg::CTRL_OFS, 0);
      c = {6'h0, dev_sel ^ 2'($urandom_range(1, 3))};
      xfer(0, c[1:0], 8'h02, 8'h00);
      chk(st[2], exp_nack(c[1:0]));
      repeat (2)
      begin
         c = cm[$urandom_range(0, 2)];
         d = 8'($urandom);
         xfer(0, dev_sel, c, d);
         chk(st[2], exp_nack(dev_sel));
         xfer(1, dev_sel, c, 0);
         chk(st[15:8], d);
      end
      chk(sel, dev_sel);
      xfer(0, dev_sel, 8'h04, 8'hff);
      pin_in[7:0] <= 8'($urandom_range(1, 255));
      repeat (4) @(posedge sys_clk);
      apb(0, expander_host_pkg::STATUS_OFS, 0);
      chk(rv[3], 1);
      xfer(1, dev_sel, 8'h00, 0);
      chk(st[15:8], pin_in[7:0]);
      apb(0, expander_host_pkg::STATUS_OFS, 0);
      chk(rv[3], 0);
      finish_test;
   end
endmodule
`default_nettype wire
